// ==== bench/tb_gpqd_top.sv ====
// Self-checking bench for the GPIO qualifier and direction block
`timescale 1ns/1ps
`include "gpqd_regs.svh"
module tb_gpqd_top;
   logic                 mclk_i  = 1'b0;
   logic                 nrst_i  = 1'b0;
   logic [`GPQD_AW-1:0]  addr_i  = '0;
   logic [`GPQD_DW-1:0]  wdata_i = '0;
   logic                 wr_i    = 1'b0;
   logic                 rd_i    = 1'b0;
   logic                 permit  = 1'b0;
   logic [`GPQD_NHI-1:0] pa      = '0;
   logic [`GPQD_NHI-1:0] fa      = '0;
   logic [`GPQD_NB-1:0]  pb      = '0;
   logic [`GPQD_NB-1:0]  fb      = '0;
   logic [`GPQD_DW-1:0]  gm      = '0;
   logic [`GPQD_DW-1:0]  lat     = '0;
   logic [`GPQD_DW-1:0]  pdo     = '0;
   logic [`GPQD_DW-1:0]  poe     = '0;
   logic [`GPQD_DW-1:0]  rdata_o;
   logic [`GPQD_NHI-1:0] ina;
   logic [`GPQD_NB-1:0]  inb;
   logic [`GPQD_DW-1:0]  pad;
   logic [`GPQD_DW-1:0]  oe;
   int                   n_mismatch = 0;
   int                   n_compared = 0;
   int                   cyc = 0;

   gpqd_top gpqd_top_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .protected_write_permit_i(permit), .pin_a_hi_i(pa), .pin_b_i(pb),
      .periph_a_hi_i(fa), .periph_b_i(fb), .in_a_hi_o(ina), .in_b_o(inb),
      .gpio_mode_a_i(gm), .port_a_output_latch_i(lat),
      .periph_dout_a_i(pdo), .periph_oe_a_i(poe), .pad_a_o(pad),
      .pad_a_oe_o(oe));

   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // A hang is cut short long after the whole sequence should be over
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask

   task automatic t_regs;
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h0);
      rdchk(8'h08, 32'h0);
      rdchk(8'h14, 32'h0);
      @(posedge mclk_i);
      permit <= 1'b0;
      wr(8'h08, 32'hFFFF_FFFF);
      rdchk(8'h08, 32'h0);
      @(posedge mclk_i);
      permit <= 1'b1;
      wr(8'h00, 32'hC3A5_5A3C);
      rdchk(8'h00, 32'hC3A5_5A3C);
      wr(8'h04, 32'hFFFF_FFFF);
      rdchk(8'h04, 32'h0000_3FFF);
      wr(8'h04, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_pads;
      gm  <= 32'h0000_FFFF;
      lat <= 32'hA5A5_A5A5;
      pdo <= 32'h5A5A_5A5A;
      poe <= 32'hFFFF_0000;
      @(posedge mclk_i);
      #1 chk(oe, 32'hFFFF_0000);
      wr(8'h08, 32'h00FF_00FF);
      #1 chk(oe, 32'hFFFF_00FF);
      chk(pad, 32'h5A5A_A5A5);
      $display("test pads done");
   endtask

   // Qualifier on pin 16; g is a glitch width that must be rejected
   task automatic qt(input logic [1:0] c, input logic [7:0] p,
                     input int g, input int lo, input int hi);
      int n;
      wr(8'h00, {30'h0, c});
      wr(8'h0C, {8'h0, p, 16'h0});
      if (g > 0) begin
         @(posedge mclk_i);
         pa[0] <= 1'b1;
         repeat (g) @(posedge mclk_i);
         pa[0] <= 1'b0;
         n = 0;
         repeat (40) begin
            @(posedge mclk_i);
            #1 if (ina[0] !== 1'b0) n++;
         end
         chk(n, 0);
      end
      @(posedge mclk_i);
      pa[0] <= 1'b1;
      n = 0;
      while (ina[0] !== 1'b1 && n < 60) begin
         @(posedge mclk_i);
         #1 n++;
      end
      chk(n >= lo && n <= hi, 1);
      @(posedge mclk_i);
      pa[0] <= 1'b0;
      repeat (40) @(posedge mclk_i);
      #1 chk(ina[0], 1'b0);
      $display("test qualifier code %0d period %0d done", c, p);
   endtask

   task automatic t_sync;
      qt(2'h0, 8'h00, 0, 3, 3);
      qt(2'h3, 8'h00, 0, 3, 3);
      @(posedge mclk_i);
      pb[0] <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1 chk(inb[0], 1'b1);
      @(posedge mclk_i);
      pb[0] <= 1'b0;
      $display("test sync done");
   endtask

   task automatic t_bypass;
      wr(8'h00, 32'h0000_0003);
      fa[0] <= 1'b1;
      @(posedge mclk_i);
      pa[0] <= 1'b1;
      #1 chk(ina[0], 1'b1);
      @(posedge mclk_i);
      pa[0] <= 1'b0;
      #1 chk(ina[0], 1'b0);
      @(posedge mclk_i);
      fa[0] <= 1'b0;
      $display("test bypass done");
   endtask

   // Pin 32 on three samples, spacing from the period low byte
   task automatic t_port_b;
      int n;
      wr(8'h04, 32'h0000_0001);
      wr(8'h0C, 32'h0000_0001);
      @(posedge mclk_i);
      pb[0] <= 1'b1;
      n = 0;
      while (inb[0] !== 1'b1 && n < 60) begin
         @(posedge mclk_i);
         #1 n++;
      end
      chk(n >= 7 && n <= 8, 1);
      @(posedge mclk_i);
      pb[0] <= 1'b0;
      repeat (20) @(posedge mclk_i);
      #1 chk(inb[0], 1'b0);
      $display("test port b done");
   endtask

   initial begin
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_regs;
      t_pads;
      t_sync;
      t_bypass;
      // Spacing is period-code driven: code 2 means four cycles apart
      qt(2'h1, 8'h00, 2, 5, 5);
      qt(2'h2, 8'h00, 5, 8, 8);
      qt(2'h2, 8'h02, 10, 23, 26);
      t_port_b;
      conclude;
   end
endmodule

// ==== hw/gpqd_pkg.sv ====
// Types shared by the GPIO qualifier block
`include "gpqd_regs.svh"
package gpqd_pkg;
   typedef logic [`GPQD_NQ-1:0] gpqd_pins_t;
   typedef logic [`GPQD_CNT_W-1:0] gpqd_cnt_t;

   typedef struct packed {
      logic [`GPQD_DW-1:0]                    sel_a;
      logic [`GPQD_SEL_B_W-1:0]               sel_b;
      logic [`GPQD_DW-1:0]                    dir_a;
      logic [`GPQD_DW-1:0]                    prd_a;
      logic [`GPQD_DW-1:0]                    rdata;
      gpqd_pins_t                             sync1;
      gpqd_pins_t                             sync2;
      gpqd_pins_t                             qual;
      logic [`GPQD_NQ-1:0][`GPQD_HIST_W-1:0]  hist;
      logic [`GPQD_NGRP-1:0][`GPQD_CNT_W-1:0] cnt;
   } gpqd_state_s;
endpackage

// ==== hw/gpqd_regs.svh ====
// Register map, field layout and codes of the GPIO qualifier block
`ifndef GPQD_REGS_SVH
`define GPQD_REGS_SVH

// Bus and register map
`define GPQD_AW          8
`define GPQD_DW          32
`define GPQD_OFS_SEL_A   8'h00
`define GPQD_OFS_SEL_B   8'h04
`define GPQD_OFS_DIR_A   8'h08
`define GPQD_OFS_PRD_A   8'h0C
`define GPQD_OFS_LEVEL   8'h10

// Reset values
`define GPQD_RST_SEL_A   32'h0000_0000
`define GPQD_RST_SEL_B   14'h0000
`define GPQD_RST_DIR_A   32'h0000_0000
`define GPQD_RST_PRD_A   32'h0000_0000

// Field layout
`define GPQD_SEL_B_W     14
`define GPQD_NHI         16
`define GPQD_NB          7
`define GPQD_NQ          23
`define GPQD_NGRP        3
`define GPQD_GRP_PINS    8
`define GPQD_PRD_W       8
`define GPQD_PRD_LSB_B   0
`define GPQD_PRD_LSB_LO  16
`define GPQD_PRD_LSB_HI  24

// Qualifier codes and sample windows
`define GPQD_Q_SYNC      2'h0
`define GPQD_Q_3         2'h1
`define GPQD_Q_6         2'h2
`define GPQD_Q_ASYNC     2'h3
`define GPQD_HIST_W      6
`define GPQD_WIN3_MSK    6'h07
`define GPQD_WIN6_MSK    6'h3F
`define GPQD_CNT_W       9
`define GPQD_CNT_ONE     9'h001

`endif

// ==== hw/gpqd_top.sv ====
// GPIO input qualifier select and port A direction control
`timescale 1ns/1ps
`include "gpqd_regs.svh"
module gpqd_top (
   // Clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 nrst_i,
   // Register port
   input  wire logic [`GPQD_AW-1:0]  addr_i,
   input  wire logic [`GPQD_DW-1:0]  wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [`GPQD_DW-1:0]  rdata_o,
   input  wire logic                 protected_write_permit_i,
   // Qualified inputs, port A upper half and port B
   input  wire logic [`GPQD_NHI-1:0] pin_a_hi_i,
   input  wire logic [`GPQD_NB-1:0]  pin_b_i,
   input  wire logic [`GPQD_NHI-1:0] periph_a_hi_i,
   input  wire logic [`GPQD_NB-1:0]  periph_b_i,
   output logic      [`GPQD_NHI-1:0] in_a_hi_o,
   output logic      [`GPQD_NB-1:0]  in_b_o,
   // Port A output drivers
   input  wire logic [`GPQD_DW-1:0]  gpio_mode_a_i,
   input  wire logic [`GPQD_DW-1:0]  port_a_output_latch_i,
   input  wire logic [`GPQD_DW-1:0]  periph_dout_a_i,
   input  wire logic [`GPQD_DW-1:0]  periph_oe_a_i,
   output logic      [`GPQD_DW-1:0]  pad_a_o,
   output logic      [`GPQD_DW-1:0]  pad_a_oe_o
);

   gpqd_pkg::gpqd_state_s                  state_ff;
   gpqd_pkg::gpqd_state_s                  nxt_state;
   gpqd_pkg::gpqd_pins_t                   pin_raw;
   gpqd_pkg::gpqd_pins_t                   periph;
   gpqd_pkg::gpqd_pins_t                   bypass;
   gpqd_pkg::gpqd_pins_t                   in_all;
   logic [`GPQD_NQ-1:0][1:0]               sel_all;
   logic [`GPQD_NGRP-1:0]                  strb;
   logic [`GPQD_NGRP-1:0][`GPQD_CNT_W-1:0] prd_cyc;
   logic [`GPQD_NGRP-1:0][`GPQD_PRD_W-1:0] prd_fld;
   logic                                   wr_ok;

   assign pin_raw = {pin_b_i, pin_a_hi_i};
   assign periph  = {periph_b_i, periph_a_hi_i};
   assign sel_all = {state_ff.sel_b, state_ff.sel_a};
   assign wr_ok   = wr_i && protected_write_permit_i;

   // Group 0: pins 16-23, group 1: pins 24-31, group 2: port B
   assign prd_fld[0] = state_ff.prd_a[`GPQD_PRD_LSB_LO +: `GPQD_PRD_W];
   assign prd_fld[1] = state_ff.prd_a[`GPQD_PRD_LSB_HI +: `GPQD_PRD_W];
   assign prd_fld[2] = state_ff.prd_a[`GPQD_PRD_LSB_B +: `GPQD_PRD_W];

   for (genvar g = 0; g < `GPQD_NGRP; g++) begin : g_prd
      // Code 0 means one clock, otherwise twice the code
      assign prd_cyc[g] = (prd_fld[g] == '0) ? `GPQD_CNT_ONE
                                             : {prd_fld[g], 1'b0};
      assign strb[g] = (state_ff.cnt[g] == '0);
   end

   // Bypass is combinational on purpose: no flop may add latency
   for (genvar k = 0; k < `GPQD_NQ; k++) begin : g_pin
      assign bypass[k] = (sel_all[k] == `GPQD_Q_ASYNC) && periph[k];
      assign in_all[k] = bypass[k] ? pin_raw[k] : state_ff.qual[k];
   end

   assign in_a_hi_o = in_all[`GPQD_NHI-1:0];
   assign in_b_o    = in_all[`GPQD_NQ-1:`GPQD_NHI];

   for (genvar i = 0; i < `GPQD_DW; i++) begin : g_pad
      // Peripheral pins keep their own enable whatever the direction
      assign pad_a_oe_o[i] = gpio_mode_a_i[i] ? state_ff.dir_a[i]
                                              : periph_oe_a_i[i];
      assign pad_a_o[i] = gpio_mode_a_i[i] ? port_a_output_latch_i[i]
                                           : periph_dout_a_i[i];
   end

   assign rdata_o = state_ff.rdata;

   always_comb begin
      logic [`GPQD_HIST_W-1:0] h;
      logic [`GPQD_HIST_W-1:0] m;
      int                      grp;
      h         = '0;
      m         = '0;
      grp       = 0;
      nxt_state = state_ff;

      nxt_state.sync1 = pin_raw;
      nxt_state.sync2 = state_ff.sync1;

      // A period change waits for the running count to expire
      for (int g = 0; g < `GPQD_NGRP; g++) begin
         if (strb[g]) begin
            nxt_state.cnt[g] = prd_cyc[g] - `GPQD_CNT_ONE;
         end else begin
            nxt_state.cnt[g] = state_ff.cnt[g] - `GPQD_CNT_ONE;
         end
      end

      // History keeps shifting in every mode; a mode change leaves it as it is
      for (int k = 0; k < `GPQD_NQ; k++) begin
         if (k < `GPQD_GRP_PINS) begin
            grp = 0;
         end else if (k < `GPQD_NHI) begin
            grp = 1;
         end else begin
            grp = 2;
         end
         h = {state_ff.hist[k][`GPQD_HIST_W-2:0], state_ff.sync2[k]};
         m = (sel_all[k] == `GPQD_Q_3) ? `GPQD_WIN3_MSK : `GPQD_WIN6_MSK;
         if (strb[grp]) begin
            nxt_state.hist[k] = h;
         end
         case (sel_all[k])
            `GPQD_Q_3, `GPQD_Q_6: begin
               if (strb[grp] && ((h & m) == m)) begin
                  nxt_state.qual[k] = 1'b1;
               end else if (strb[grp] && ((h & m) == '0)) begin
                  nxt_state.qual[k] = 1'b0;
               end
            end
            default: begin
               nxt_state.qual[k] = state_ff.sync2[k];
            end
         endcase
      end

      // Period register is protected like the selectors
      if (wr_ok) begin
         case (addr_i)
            `GPQD_OFS_SEL_A: begin
               nxt_state.sel_a = wdata_i;
            end
            `GPQD_OFS_SEL_B: begin
               nxt_state.sel_b = wdata_i[`GPQD_SEL_B_W-1:0];
            end
            `GPQD_OFS_DIR_A: begin
               nxt_state.dir_a = wdata_i;
            end
            `GPQD_OFS_PRD_A: begin
               nxt_state.prd_a = wdata_i;
            end
            default: begin
            end
         endcase
      end

      // Read data stands for one cycle and is zero otherwise
      nxt_state.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            `GPQD_OFS_SEL_A: begin
               nxt_state.rdata = state_ff.sel_a;
            end
            `GPQD_OFS_SEL_B: begin
               nxt_state.rdata = {{(`GPQD_DW-`GPQD_SEL_B_W){1'b0}},
                                  state_ff.sel_b};
            end
            `GPQD_OFS_DIR_A: begin
               nxt_state.rdata = state_ff.dir_a;
            end
            `GPQD_OFS_PRD_A: begin
               nxt_state.rdata = state_ff.prd_a;
            end
            `GPQD_OFS_LEVEL: begin
               nxt_state.rdata = {{(`GPQD_DW-`GPQD_NQ){1'b0}},
                                  state_ff.qual};
            end
            default: begin
               nxt_state.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= '{sel_a: `GPQD_RST_SEL_A,
                       sel_b: `GPQD_RST_SEL_B,
                       dir_a: `GPQD_RST_DIR_A,
                       prd_a: `GPQD_RST_PRD_A,
                       default: '0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // Pins 16 and 32 stand in for their groups below, pad pins 0, 2, 3 and 5 for port A

   a_sel_a_readback: assert property (
      wr_ok && addr_i == `GPQD_OFS_SEL_A ##1 !wr_i ##1
      rd_i && addr_i == `GPQD_OFS_SEL_A
      |=> rdata_o == $past(wdata_i, 3))
      else $error("upper port A selector readback wrong");

   a_sync_only: assert property (
      (sel_all[0] == `GPQD_Q_SYNC)[*4]
      |-> in_a_hi_o[0] == $past(pin_a_hi_i[0], 3))
      else $error("sync mode not three cycles behind pin");

   a_qual3_set: assert property (
      strb[0] && !wr_i && sel_all[0] == `GPQD_Q_3 &&
      state_ff.sync2[0] && state_ff.hist[0][1:0] == 2'h3
      |=> in_a_hi_o[0])
      else $error("three agreeing samples did not set level");

   a_qual6_clr: assert property (
      strb[0] && !wr_i && sel_all[0] == `GPQD_Q_6 &&
      !state_ff.sync2[0] && state_ff.hist[0][4:0] == 5'h00
      |=> !in_a_hi_o[0])
      else $error("six agreeing samples did not clear level");

   a_port_b_period: assert property (
      strb[2] && prd_fld[2] == 8'h01
      |=> !strb[2] ##1 strb[2])
      else $error("port B sample spacing not from period field");

   a_async_pass: assert property (
      wr_ok && addr_i == `GPQD_OFS_SEL_A &&
      wdata_i[1:0] == `GPQD_Q_ASYNC ##1 periph_a_hi_i[0]
      |-> in_a_hi_o[0] == pin_a_hi_i[0])
      else $error("async peripheral pin not bypassed");

   a_async_gpio: assert property (
      (sel_all[0] == `GPQD_Q_ASYNC && !periph_a_hi_i[0])[*4]
      |-> in_a_hi_o[0] == $past(pin_a_hi_i[0], 3))
      else $error("async code on GPIO pin not synchronized");

   a_sel_b_reserved: assert property (
      rd_i && addr_i == `GPQD_OFS_SEL_B
      |=> rdata_o[`GPQD_DW-1:`GPQD_SEL_B_W] == '0)
      else $error("port B selector reserved bits not zero");

   a_periph_pad: assert property (
      !gpio_mode_a_i[0]
      |-> pad_a_oe_o[0] == periph_oe_a_i[0] &&
          pad_a_o[0] == periph_dout_a_i[0])
      else $error("direction reached a peripheral pin");

   a_dir_write: assert property (
      wr_ok && addr_i == `GPQD_OFS_DIR_A
      |=> gpio_mode_a_i[5] |-> pad_a_oe_o[5] == $past(wdata_i[5]))
      else $error("direction write did not steer output enable");

   a_out_latch: assert property (
      gpio_mode_a_i[3] && pad_a_oe_o[3]
      |-> pad_a_o[3] == port_a_output_latch_i[3])
      else $error("output pin not driving the data latch");

   a_write_protect: assert property (
      wr_i && !protected_write_permit_i
      |=> $stable(state_ff.sel_a) && $stable(state_ff.sel_b) &&
          $stable(state_ff.dir_a) && $stable(state_ff.prd_a))
      else $error("protected register changed without permit");

   a_period_zero: assert property (
      strb[1] && prd_fld[1] == 8'h00 |=> strb[1])
      else $error("period code zero is not one cycle");

   a_qual_hold: assert property (
      sel_all[0] == `GPQD_Q_3 && $stable(sel_all[0]) &&
      $changed(in_a_hi_o[0])
      |-> $past(strb[0]))
      else $error("qualified level moved between samples");

   a_sel_b_readback: assert property (
      wr_ok && addr_i == `GPQD_OFS_SEL_B ##1 !wr_i ##1
      rd_i && addr_i == `GPQD_OFS_SEL_B
      |=> rdata_o[`GPQD_SEL_B_W-1:0] ==
          $past(wdata_i[`GPQD_SEL_B_W-1:0], 3))
      else $error("port B selector readback wrong");

   a_dir_hold: assert property (
      gpio_mode_a_i[2] && $stable(gpio_mode_a_i[2]) && !$past(wr_ok)
      |-> $stable(pad_a_oe_o[2]))
      else $error("direction changed without a permitted write");

   a_dir_reset: assert property (
      $rose(nrst_i) |-> state_ff.dir_a == '0)
      else $error("direction not input after reset");

   a_sync_b: assert property (
      (sel_all[`GPQD_NHI] == `GPQD_Q_SYNC)[*4]
      |-> in_b_o[0] == $past(pin_b_i[0], 3))
      else $error("port B sync mode not three cycles behind pin");

   a_qual3_clr: assert property (
      strb[0] && !wr_i && sel_all[0] == `GPQD_Q_3 &&
      !state_ff.sync2[0] && state_ff.hist[0][1:0] == 2'h0
      |=> !in_a_hi_o[0])
      else $error("three agreeing samples did not clear level");

   a_qual6_set: assert property (
      strb[0] && !wr_i && sel_all[0] == `GPQD_Q_6 &&
      state_ff.sync2[0] && state_ff.hist[0][4:0] == 5'h1F
      |=> in_a_hi_o[0])
      else $error("six agreeing samples did not set level");

   a_qual3_b: assert property (
      strb[2] && !wr_i && sel_all[`GPQD_NHI] == `GPQD_Q_3 &&
      state_ff.sync2[`GPQD_NHI] &&
      state_ff.hist[`GPQD_NHI][1:0] == 2'h3
      |=> in_b_o[0])
      else $error("port B three agreeing samples did not set level");

   a_qual6_hold: assert property (
      sel_all[0] == `GPQD_Q_6 && $stable(sel_all[0]) &&
      $changed(in_a_hi_o[0])
      |-> $past(strb[0]))
      else $error("six-sample level moved between samples");

   a_rise_agree: assert property (
      sel_all[0] == `GPQD_Q_3 && $stable(sel_all[0]) &&
      $rose(in_a_hi_o[0])
      |-> $past(state_ff.sync2[0]) && $past(state_ff.hist[0][1]) &&
          $past(state_ff.hist[0][0]))
      else $error("three-sample level rose without agreement");

   a_fall_agree: assert property (
      sel_all[0] == `GPQD_Q_6 && $stable(sel_all[0]) &&
      $fell(in_a_hi_o[0])
      |-> !$past(state_ff.sync2[0]) &&
          $past(state_ff.hist[0][4:0]) == 5'h00)
      else $error("six-sample level fell without agreement");

   a_period_two: assert property (
      strb[0] && prd_fld[0] == 8'h02
      |=> (!strb[0])[*3] ##1 strb[0])
      else $error("period code two is not four cycles");

   a_dir_write_lands: assert property (
      wr_ok && addr_i == `GPQD_OFS_DIR_A
      |=> state_ff.dir_a == $past(wdata_i))
      else $error("permitted direction write did not land");

   a_sel_b_write: assert property (
      wr_ok && addr_i == `GPQD_OFS_SEL_B
      |=> state_ff.sel_b == $past(wdata_i[`GPQD_SEL_B_W-1:0]))
      else $error("permitted port B selector write did not land");

endmodule
